// File: design/see_core.sv
// Serial EEPROM client: opcode decode, address, page write, status and busy timing
`timescale 1ns/100ps
module see_core #(
  parameter int P_PAGE_BYTES = see_pkg::PAGE_BYTES_D,
  parameter int P_TWC_CYCLES = see_pkg::TWC_CYCLES
) (
  input  wire logic i_clk,
  input  wire logic i_sys_rst,
  input  wire logic i_cs_n,
  input  wire logic i_sck,
  input  wire logic i_si,
  input  wire logic i_hold_n,
  input  wire logic i_wp_n,
  output logic      o_so,
  output logic      o_so_oe_n
);
  localparam int              PW        = see_pkg::PAGE_W;
  localparam int              AW        = see_pkg::ADDR_W;
  localparam int              TW        = $clog2(P_TWC_CYCLES + 1);
  localparam logic [PW-1:0]   PAGE_MASK = PW'(P_PAGE_BYTES - 1);
  localparam logic [PW:0]     PAGE_LAST = (PW + 1)'(P_PAGE_BYTES - 1);
  localparam logic [TW-1:0]   TWC_LAST  = TW'(P_TWC_CYCLES - 1);

  typedef struct packed {
    see_pkg::see_state_e st;
    logic                sck;
    logic                cs_n;
    logic [3:0]          bit_cnt;
    logic [7:0]          in_sh;
    logic [7:0]          cmd;
    logic [AW-1:0]       addr;
    logic                bnd;
    logic [7:0]          out_sh;
    logic                so;
    logic                so_oe_n;
    logic                write_latch_flag;
    logic                pin_protect_enable;
    logic [1:0]          bp;
    logic                busy;
    logic [TW-1:0]       twc;
    logic [PW:0]         cidx;
    logic                commit;
    logic [31:0]         mask;
    logic [PW-1:0]       woff;
    logic [AW-1:0]       wbase;
    logic [7:0]          sr_new;
  } see_core_s;

  see_core_s     q_q;
  see_core_s     q_d;
  logic [4:0]    pin_s;
  logic          cs_n_s;
  logic          sck_s;
  logic          si_s;
  logic          hold_s;
  logic          wp_n_s;
  logic          act;
  logic          rise;
  logic          fall;
  logic          cs_rise;
  logic          cs_fall;
  logic          byte_end;
  logic [7:0]    sh_n;
  logic [7:0]    status;
  logic [7:0]    rd_data;
  logic          buf_we;
  logic          arr_we;
  logic [AW-1:0] arr_addr;

  see_sync #(
    .W (5)
  ) u_sync (
    .i_clk     (i_clk),
    .i_sys_rst (i_sys_rst),
    .i_d       ({i_wp_n, i_hold_n, i_si, i_sck, i_cs_n}),
    .o_q       (pin_s)
  );

  assign cs_n_s   = pin_s[0];
  assign sck_s    = pin_s[1];
  assign si_s     = pin_s[2];
  assign hold_s   = pin_s[3];
  assign wp_n_s   = pin_s[4];
  // Edges are ignored while paused, so the sequence resumes where it stopped
  assign act      = !cs_n_s && hold_s;
  assign rise     = act && sck_s && !q_q.sck;
  assign fall     = act && !sck_s && q_q.sck;
  assign cs_rise  = cs_n_s && !q_q.cs_n;
  assign cs_fall  = !cs_n_s && q_q.cs_n;
  assign byte_end = q_q.bit_cnt[2:0] == 3'h7;
  assign sh_n     = {q_q.in_sh[6:0], si_s};
  assign arr_addr = q_q.wbase | AW'(q_q.cidx[PW-1:0]);

  function automatic logic prot_f(input logic [1:0] bp, input logic [AW-1:0] a);
    case (bp)
      2'h0:    prot_f = 1'b0;
      2'h1:    prot_f = a >= see_pkg::PROT_QUARTER;
      2'h2:    prot_f = a >= see_pkg::PROT_HALF;
      default: prot_f = 1'b1;
    endcase
  endfunction

  always_comb begin
    q_d    = q_q;
    buf_we = 1'b0;
    arr_we = 1'b0;
    status = see_pkg::SR_RESET;
    status[see_pkg::SR_PIN_PROTECT_BIT] = q_q.pin_protect_enable;
    status[see_pkg::SR_BP_HIGH_BIT]     = q_q.bp[1];
    status[see_pkg::SR_BP_LOW_BIT]      = q_q.bp[0];
    status[see_pkg::SR_LATCH_BIT]       = q_q.write_latch_flag;
    status[see_pkg::SR_BUSY_BIT]        = q_q.busy;
    q_d.sck  = sck_s;
    q_d.cs_n = cs_n_s;

    // Internal write cycle: copy staged bytes, then wait out the write time
    if (q_q.busy) begin
      q_d.twc = TW'(q_q.twc + 1'b1);
      if (q_q.commit) begin
        arr_we   = q_q.mask[q_q.cidx[PW-1:0]] && !prot_f(q_q.bp, arr_addr);
        q_d.cidx = (PW + 1)'(q_q.cidx + 1'b1);
        if (q_q.cidx == PAGE_LAST) begin
          q_d.commit = 1'b0;
        end
      end
      if (q_q.twc == TWC_LAST) begin
        q_d.busy = 1'b0;
        q_d.write_latch_flag  = 1'b0;
      end
    end

    if (cs_rise) begin
      case (q_q.st)
        see_pkg::ST_SKIP: begin
          if (q_q.bnd && q_q.cmd == see_pkg::OP_LATCH_SET) begin
            q_d.write_latch_flag = 1'b1;
          end else if (q_q.bnd && q_q.cmd == see_pkg::OP_LATCH_CLEAR) begin
            q_d.write_latch_flag = 1'b0;
          end
        end
        see_pkg::ST_WDATA: begin
          // Deselect anywhere but a byte end aborts the write
          if (q_q.bnd && q_q.write_latch_flag && !q_q.busy) begin
            q_d.busy   = 1'b1;
            q_d.commit = 1'b1;
            q_d.twc    = '0;
            q_d.cidx   = '0;
          end
        end
        see_pkg::ST_SWR: begin
          if (q_q.bnd && q_q.write_latch_flag && !q_q.busy && !(q_q.pin_protect_enable && !wp_n_s)) begin
            q_d.pin_protect_enable = q_q.sr_new[see_pkg::SR_PIN_PROTECT_BIT];
            q_d.bp   = {q_q.sr_new[see_pkg::SR_BP_HIGH_BIT],
                        q_q.sr_new[see_pkg::SR_BP_LOW_BIT]};
            q_d.busy = 1'b1;
            q_d.twc  = '0;
          end
        end
        default: ;
      endcase
      q_d.st      = see_pkg::ST_IDLE;
      q_d.so_oe_n = 1'b1;
      q_d.bnd     = 1'b0;
    end else if (cs_fall) begin
      q_d.st      = see_pkg::ST_OPCODE;
      q_d.bit_cnt = 4'h0;
      q_d.bnd     = 1'b0;
    end else if (rise) begin
      q_d.in_sh   = sh_n;
      q_d.bit_cnt = byte_end ? 4'h0 : 4'(q_q.bit_cnt + 4'h1);
      case (q_q.st)
        see_pkg::ST_OPCODE: begin
          if (byte_end) begin
            q_d.cmd = sh_n;
            q_d.bnd = 1'b1;
            case (sh_n)
              see_pkg::OP_READ,
              see_pkg::OP_WRITE: begin
                // Array commands are dropped while a write cycle runs
                q_d.st = q_q.busy ? see_pkg::ST_SKIP : see_pkg::ST_ADDR;
              end
              see_pkg::OP_STATUS_READ:  q_d.st = see_pkg::ST_SRD;
              see_pkg::OP_STATUS_WRITE: q_d.st = see_pkg::ST_SWR;
              default:                  q_d.st = see_pkg::ST_SKIP;
            endcase
          end
        end
        see_pkg::ST_ADDR: begin
          q_d.bit_cnt = 4'(q_q.bit_cnt + 4'h1);
          // The opcode's byte end must not count as a data byte end
          q_d.bnd     = 1'b0;
          // Only the low bits are kept; the top five shift out unused
          q_d.addr    = {q_q.addr[AW-2:0], si_s};
          if (q_q.bit_cnt == see_pkg::ADDR_LAST_BIT) begin
            q_d.bit_cnt = 4'h0;
            if (q_q.cmd == see_pkg::OP_READ) begin
              q_d.st = see_pkg::ST_RDATA;
            end else begin
              q_d.st    = see_pkg::ST_WDATA;
              q_d.wbase = {q_q.addr[AW-2:0], si_s} & ~AW'(PAGE_MASK);
              q_d.woff  = {q_q.addr[PW-2:0], si_s} & PAGE_MASK;
              q_d.mask  = '0;
            end
          end
        end
        see_pkg::ST_WDATA: begin
          q_d.bnd = byte_end;
          if (byte_end) begin
            buf_we                = 1'b1;
            q_d.mask[q_q.woff]    = 1'b1;
            q_d.woff              = PW'(q_q.woff + 1'b1) & PAGE_MASK;
          end
        end
        see_pkg::ST_SWR: begin
          q_d.bnd = byte_end;
          if (byte_end) begin
            q_d.sr_new = sh_n;
          end
        end
        see_pkg::ST_SKIP: q_d.bnd = 1'b0;
        default: ;
      endcase
    end else if (fall) begin
      if (q_q.st == see_pkg::ST_RDATA || q_q.st == see_pkg::ST_SRD) begin
        q_d.so_oe_n = 1'b0;
        if (q_q.bit_cnt[2:0] == 3'h0) begin
          if (q_q.st == see_pkg::ST_RDATA) begin
            q_d.so     = rd_data[7];
            q_d.out_sh = {rd_data[6:0], 1'b0};
            q_d.addr   = AW'(q_q.addr + 1'b1);
          end else begin
            q_d.so     = status[7];
            q_d.out_sh = {status[6:0], 1'b0};
          end
        end else begin
          q_d.so     = q_q.out_sh[7];
          q_d.out_sh = {q_q.out_sh[6:0], 1'b0};
        end
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      q_q         <= '0;
      q_q.st      <= see_pkg::ST_IDLE;
      q_q.sck     <= 1'b1;
      q_q.cs_n    <= 1'b1;
      q_q.so_oe_n <= 1'b1;
      q_q.write_latch_flag     <= 1'b0;
    end else begin
      q_q <= q_d;
    end
  end

  see_mem #(
    .AW (AW),
    .PW (PW)
  ) u_mem (
    .i_clk      (i_clk),
    .i_buf_we   (buf_we),
    .i_buf_idx  (q_q.woff),
    .i_buf_data (sh_n),
    .i_arr_we   (arr_we),
    .i_arr_addr (arr_addr),
    .i_arr_idx  (q_q.cidx[PW-1:0]),
    .i_rd_addr  (q_q.addr),
    .o_rd_data  (rd_data)
  );

  assign o_so      = q_q.so;
  // Output floats at once when paused, whatever the clock does
  assign o_so_oe_n = q_q.so_oe_n || !hold_s;

  // Checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);

  sequence s_latch_cmd_done(logic [7:0] op);
    cs_rise && q_q.st == see_pkg::ST_SKIP && q_q.bnd && q_q.cmd == op;
  endsequence

  sequence s_write_start;
    cs_rise && q_q.st == see_pkg::ST_WDATA && q_q.bnd && q_q.write_latch_flag && !q_q.busy;
  endsequence

  chk_latch_set_edge: assert property (
    s_latch_cmd_done(see_pkg::OP_LATCH_SET) |=> q_q.write_latch_flag)
    else $error("latch not set after latch-set command");

  chk_latch_clear_edge: assert property (
    s_latch_cmd_done(see_pkg::OP_LATCH_CLEAR) |=> !q_q.write_latch_flag)
    else $error("latch not cleared after latch-clear command");

  chk_write_starts_busy: assert property (
    s_write_start |=> q_q.busy && q_q.commit && q_q.twc == '0 ##1 q_q.busy[*4])
    else $error("write cycle did not start cleanly");

  chk_write_abort_off: assert property (
    cs_rise && q_q.st == see_pkg::ST_WDATA && !q_q.bnd && !q_q.busy |=> !q_q.busy)
    else $error("write started on misaligned deselect");

  chk_busy_read_refused: assert property (
    rise && q_q.st == see_pkg::ST_OPCODE && byte_end && sh_n == see_pkg::OP_READ
      && q_q.busy |=> q_q.st == see_pkg::ST_SKIP)
    else $error("array read accepted during write cycle");

  chk_read_addr_wrap: assert property (
    fall && q_q.st == see_pkg::ST_RDATA && q_q.bit_cnt[2:0] == 3'h0
      && q_q.addr == see_pkg::ADDR_LAST |=> q_q.addr == '0)
    else $error("read pointer did not wrap to zero");

  chk_pause_freeze: assert property (
    !cs_n_s && !hold_s && q_q.cs_n == cs_n_s |=> $stable(q_q.in_sh) && $stable(q_q.bit_cnt))
    else $error("shift state moved while paused");

  chk_busy_end_latch: assert property (
    q_q.busy && q_q.twc == TWC_LAST
      && !(cs_rise && q_q.st == see_pkg::ST_SKIP && q_q.cmd == see_pkg::OP_LATCH_SET)
      |=> !q_q.busy && !q_q.write_latch_flag)
    else $error("write cycle end did not clear busy and latch");

  chk_protected_array: assert property (
    arr_we |-> q_q.bp == 2'h0
      || (q_q.bp == 2'h1 && arr_addr < see_pkg::PROT_QUARTER)
      || (q_q.bp == 2'h2 && arr_addr < see_pkg::PROT_HALF))
    else $error("protected array byte written");

  chk_status_protect: assert property (
    cs_rise && q_q.st == see_pkg::ST_SWR && q_q.pin_protect_enable && !wp_n_s
      |=> $stable(q_q.bp) && $stable(q_q.pin_protect_enable))
    else $error("protected status bits changed");
endmodule

// File: inc/see_pkg.sv
// Shared constants and types for the serial EEPROM client logic
package see_pkg;
  // Opcodes
  localparam logic [7:0] OP_READ         = 8'h03;
  localparam logic [7:0] OP_WRITE        = 8'h02;
  localparam logic [7:0] OP_LATCH_CLEAR  = 8'h04;
  localparam logic [7:0] OP_LATCH_SET    = 8'h06;
  localparam logic [7:0] OP_STATUS_READ  = 8'h05;
  localparam logic [7:0] OP_STATUS_WRITE = 8'h01;

  // Status byte layout
  localparam int         SR_PIN_PROTECT_BIT = 7;
  localparam int         SR_BP_HIGH_BIT     = 3;
  localparam int         SR_BP_LOW_BIT      = 2;
  localparam int         SR_LATCH_BIT       = 1;
  localparam int         SR_BUSY_BIT        = 0;
  localparam logic [7:0] SR_RESET           = 8'h00;

  // Array geometry
  localparam int          ADDR_W          = 11;
  localparam logic [3:0]  ADDR_LAST_BIT   = 4'hf;
  localparam logic [10:0] ADDR_LAST       = 11'h7ff;
  localparam logic [10:0] PROT_QUARTER    = 11'h600;
  localparam logic [10:0] PROT_HALF       = 11'h400;
  localparam int          PAGE_BYTES_C    = 16;
  localparam int          PAGE_BYTES_D    = 32;
  localparam int          PAGE_W          = 5;

  // Timing
  localparam int SYNC_STAGES   = 3;
  localparam int CLK_PERIOD_NS = 5;
  localparam int TWC_MS        = 5;
  localparam int TWC_CYCLES    = TWC_MS * 1000000 / CLK_PERIOD_NS;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'h0,
    ST_OPCODE = 3'h1,
    ST_ADDR   = 3'h3,
    ST_RDATA  = 3'h2,
    ST_WDATA  = 3'h6,
    ST_SRD    = 3'h7,
    ST_SWR    = 3'h5,
    ST_SKIP   = 3'h4
  } see_state_e;
endpackage

// File: design/see_sync.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/100ps
module see_sync #(
  parameter int W = 1
) (
  input  wire logic         i_clk,
  input  wire logic         i_sys_rst,
  input  wire logic [W-1:0] i_d,
  output logic      [W-1:0] o_q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } see_sync_s;

  see_sync_s    q_q;
  see_sync_s    q_d;
  logic [W-1:0] q_nxt;

  // A change counts only once stages two and three agree
  for (genvar i = 0; i < W; i++) begin : g_bit
    assign q_nxt[i] = (q_q.s2[i] == q_q.s3[i]) ? q_q.s3[i] : q_q.q[i];
  end

  always_comb begin
    q_d    = q_q;
    q_d.s1 = i_d;
    q_d.s2 = q_q.s1;
    q_d.s3 = q_q.s2;
    q_d.q  = q_nxt;
  end

  // Idle level of every pin is high after reset
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      q_q <= '1;
    end else begin
      q_q <= q_d;
    end
  end

  assign o_q = q_q.q;
endmodule

// File: design/see_mem.sv
// Byte array with page buffer and registered read port
`timescale 1ns/100ps
module see_mem #(
  parameter int AW = 11,
  parameter int PW = 5
) (
  input  wire logic          i_clk,
  input  wire logic          i_buf_we,
  input  wire logic [PW-1:0] i_buf_idx,
  input  wire logic [7:0]    i_buf_data,
  input  wire logic          i_arr_we,
  input  wire logic [AW-1:0] i_arr_addr,
  input  wire logic [PW-1:0] i_arr_idx,
  input  wire logic [AW-1:0] i_rd_addr,
  output logic      [7:0]    o_rd_data
);
  logic [7:0] arr_q [2**AW];
  logic [7:0] buf_q [2**PW];

  // Page bytes are staged here so an aborted sequence never touches the array
  always_ff @(posedge i_clk) begin
    if (i_buf_we) begin
      buf_q[i_buf_idx] <= i_buf_data;
    end
    if (i_arr_we) begin
      arr_q[i_arr_addr] <= buf_q[i_arr_idx];
    end
    o_rd_data <= arr_q[i_rd_addr];
  end
endmodule

// File: testbench/see_host.sv
// SPI host model that drives the serial link of the EEPROM client
`timescale 1ns/100ps
module see_host (
  input  wire logic i_clk,
  input  wire logic i_so,
  input  wire logic i_so_oe_n,
  output logic      o_cs_n,
  output logic      o_sck,
  output logic      o_si,
  output logic      o_hold_n
);
  logic so_last;

  // Link clock idles high between frames so the synchronisers leave reset quietly
  initial begin
    o_cs_n   = 1'b1;
    o_sck    = 1'b1;
    o_si     = 1'b0;
    o_hold_n = 1'b1;
    so_last  = 1'b0;
  end

  // Eight system clocks are half of the 80 ns link period
  task automatic half();
    repeat (8) @(posedge i_clk);
  endtask

  task automatic sel();
    o_cs_n <= 1'b0;
    half();
  endtask

  // Select rises a whole link period after the last rising edge
  task automatic desel();
    half();
    o_cs_n <= 1'b1;
    repeat (16) @(posedge i_clk);
  endtask

  // Most significant bit first; the returned line is read just before each rise
  task automatic shift(input logic [7:0] tx, input int n, output logic [7:0] rx);
    for (int i = 7; i > 7 - n; i--) begin
      o_sck <= 1'b0;
      o_si  <= tx[i];
      half();
      rx[i]   = i_so_oe_n ? ~so_last : i_so;
      so_last = rx[i];
      o_sck <= 1'b1;
      half();
    end
  endtask

  // Link clock and data keep toggling while paused; they must be ignored
  task automatic pause();
    o_hold_n <= 1'b0;
    half();
    repeat (2) begin
      o_sck <= 1'b0;
      o_si  <= ~o_si;
      half();
      o_sck <= 1'b1;
      half();
    end
    o_hold_n <= 1'b1;
    half();
  endtask
endmodule

// File: testbench/see_core_tb_top.sv
// Self-checking bench for the serial EEPROM client, driven through a host model
`timescale 1ns/100ps
`define CHK(nm, ex, gt) \
  begin \
    n_compared++; \
    if ((gt) !== (ex)) begin \
      err_count++; \
      $display("mismatch %s expected %h seen %h", nm, ex, gt); \
    end \
  end
module see_core_tb_top;
  // Short write cycle keeps the run small; small page exercises the wrap
  localparam int PAGE = 16;
  localparam int TWC  = 1500;
  typedef struct packed {
    logic [15:0] wa;
    logic [7:0]  wd;
    logic [15:0] ra;
    logic [7:0]  exp;
  } see_row_s;
  logic       i_clk;
  logic       i_sys_rst;
  logic       i_wp_n;
  logic       cs_n, sck, si, hold_n, so, so_oe_n;
  int         err_count;
  int         n_compared;
  logic [7:0] s;
  logic [15:0] r;
  see_row_s   rows [4] = '{'{16'hf812, 8'ha5, 16'h0012, 8'ha5},
                           '{16'h07ff, 8'h3c, 16'h07ff, 8'h3c},
                           '{16'h0000, 8'hc3, 16'h0000, 8'hc3},
                           '{16'h0155, 8'h5a, 16'h0155, 8'h5a}};

  initial i_clk = 1'b0;
  always #2.5 i_clk = ~i_clk;

  see_core #(.P_PAGE_BYTES(PAGE), .P_TWC_CYCLES(TWC)) DUT (
    .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_cs_n(cs_n), .i_sck(sck), .i_si(si),
    .i_hold_n(hold_n), .i_wp_n(i_wp_n), .o_so(so), .o_so_oe_n(so_oe_n));
  see_host u_host (.i_clk(i_clk), .i_so(so), .i_so_oe_n(so_oe_n), .o_cs_n(cs_n),
    .o_sck(sck), .o_si(si), .o_hold_n(hold_n));

  task automatic stop_test();
    $display("compared %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic cmd(input logic [7:0] op);
    logic [7:0] d;
    u_host.sel();
    u_host.shift(op, 8, d);
    u_host.desel();
  endtask

  task automatic status_read_cmd(output logic [7:0] v);
    logic [7:0] d;
    u_host.sel();
    u_host.shift(see_pkg::OP_STATUS_READ, 8, d);
    u_host.shift(8'h00, 8, v);
    u_host.desel();
  endtask

  // Polls the busy flag; a cycle that never ends closes the run
  task automatic idle();
    int k;
    for (k = 0; k < 40; k++) begin
      status_read_cmd(s);
      if (s[see_pkg::SR_BUSY_BIT] === 1'b0) break;
    end
    if (k == 40) begin
      err_count++;
      stop_test();
    end
  endtask

  task automatic aopen(input logic [7:0] op, input logic [15:0] a);
    logic [7:0] d;
    u_host.sel();
    u_host.shift(op, 8, d);
    u_host.shift(a[15:8], 8, d);
    u_host.shift(a[7:0], 8, d);
  endtask

  task automatic rd(input logic [15:0] a, output logic [15:0] v);
    aopen(see_pkg::OP_READ, a);
    u_host.shift(8'h00, 8, v[15:8]);
    u_host.shift(8'h00, 8, v[7:0]);
    u_host.desel();
    `CHK("release", 1'b1, so_oe_n)
  endtask

  task automatic wr(input logic [15:0] a, input logic [23:0] d, input int nb);
    logic [7:0] x;
    cmd(see_pkg::OP_LATCH_SET);
    aopen(see_pkg::OP_WRITE, a);
    for (int i = 0; i < nb; i++) u_host.shift(d[23-8*i -: 8], 8, x);
    u_host.desel();
  endtask

  task automatic wsr(input logic [7:0] v);
    logic [7:0] x;
    cmd(see_pkg::OP_LATCH_SET);
    u_host.sel();
    u_host.shift(see_pkg::OP_STATUS_WRITE, 8, x);
    u_host.shift(v, 8, x);
    u_host.desel();
    idle();
  endtask

  initial begin
    i_sys_rst  = 1'b1;
    i_wp_n     = 1'b1;
    err_count  = 0;
    n_compared = 0;
    repeat (5) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    repeat (8) @(posedge i_clk);
    status_read_cmd(s);
    `CHK("status at reset", see_pkg::SR_RESET, s)
    cmd(see_pkg::OP_LATCH_SET);
    status_read_cmd(s);
    `CHK("latch set", 8'h02, s)
    cmd(see_pkg::OP_LATCH_CLEAR);
    status_read_cmd(s);
    `CHK("latch clear", 8'h00, s)
    foreach (rows[i]) begin
      wr(rows[i].wa, {rows[i].wd, 16'h0000}, 1);
      idle();
      rd(rows[i].ra, r);
      `CHK("row read", rows[i].exp, r[15:8])
    end
    rd(16'h07ff, r);
    `CHK("read wrap", 16'h3cc3, r)
    wr(16'h002e, 24'h11_2233, 3);
    status_read_cmd(s);
    `CHK("busy status", 8'h03, s)
    aopen(see_pkg::OP_READ, 16'h0012);
    u_host.shift(8'h00, 8, s);
    `CHK("read refused", 1'b1, so_oe_n)
    u_host.desel();
    idle();
    `CHK("latch after write", 8'h00, s)
    rd(16'h002e, r);
    `CHK("page fill", 16'h1122, r)
    rd(16'h0020, r);
    `CHK("page wrap", 8'h33, r[15:8])
    // Write glued onto the latch-set frame must be dropped
    u_host.sel();
    u_host.shift(see_pkg::OP_LATCH_SET, 8, s);
    aopen(see_pkg::OP_WRITE, 16'h0155);
    u_host.shift(8'hff, 8, s);
    u_host.desel();
    status_read_cmd(s);
    `CHK("no latch", 8'h00, s)
    rd(16'h0155, r);
    `CHK("glued write", 8'h5a, r[15:8])
    // Select rising mid-byte aborts the write
    cmd(see_pkg::OP_LATCH_SET);
    aopen(see_pkg::OP_WRITE, 16'h0155);
    u_host.shift(8'hee, 8, s);
    u_host.shift(8'h77, 4, s);
    u_host.desel();
    status_read_cmd(s);
    `CHK("abort status", 8'h02, s)
    rd(16'h0155, r);
    `CHK("abort data", 8'h5a, r[15:8])
    // Deselect straight after the address carries no data byte
    aopen(see_pkg::OP_WRITE, 16'h0155);
    u_host.desel();
    status_read_cmd(s);
    `CHK("empty write", 8'h02, s)
    cmd(see_pkg::OP_LATCH_CLEAR);
    u_host.sel();
    u_host.shift(see_pkg::OP_READ, 8, s);
    u_host.shift(8'h00, 8, s);
    u_host.pause();
    u_host.shift(8'h12, 8, s);
    u_host.shift(8'h00, 8, s);
    u_host.desel();
    `CHK("paused read", 8'ha5, s)
    wsr(8'h04);
    status_read_cmd(s);
    `CHK("protect set", 8'h04, s)
    wr(16'h07ff, 24'h99_0000, 1);
    idle();
    rd(16'h07ff, r);
    `CHK("protected", 8'h3c, r[15:8])
    wr(16'h05ff, 24'h66_0000, 1);
    idle();
    rd(16'h05ff, r);
    `CHK("unprotected", 8'h66, r[15:8])
    wsr(8'h84);
    i_wp_n <= 1'b0;
    wsr(8'h00);
    status_read_cmd(s);
    `CHK("status locked", 8'h84, s & 8'hfd)
    i_wp_n <= 1'b1;
    wsr(8'h00);
    status_read_cmd(s);
    `CHK("status unlocked", 8'h00, s)
    // Reset in mid-run must drop a set latch and float the output
    cmd(see_pkg::OP_LATCH_SET);
    i_sys_rst <= 1'b1;
    repeat (5) @(posedge i_clk);
    `CHK("output at reset", 1'b1, so_oe_n)
    i_sys_rst <= 1'b0;
    repeat (8) @(posedge i_clk);
    status_read_cmd(s);
    `CHK("status after reset", see_pkg::SR_RESET, s)
    stop_test();
  end
endmodule
